// ### design/spimp_consts.svh
`ifndef SPIMP_CONSTS_SVH
`define SPIMP_CONSTS_SVH

// Opcodes
`define SPIMP_OP_SET_WRITE_LATCH 8'h06
`define SPIMP_OP_CLEAR_WRITE_LATCH 8'h04
`define SPIMP_OP_STATUS_READ 8'h05
`define SPIMP_OP_STATUS_WRITE 8'h01
`define SPIMP_OP_READ 8'h03
`define SPIMP_OP_QUICK_READ 8'h0b
`define SPIMP_OP_WRITE 8'h02

// Status register layout
`define SPIMP_SR_LATCH_BIT 1
`define SPIMP_SR_GUARD_LO_BIT 2
`define SPIMP_SR_GUARD_HI_BIT 3
`define SPIMP_SR_PIN_EN_BIT 7
`define SPIMP_SR_RESET 8'h00

// Block guard codes
`define SPIMP_GUARD_NONE 2'h0
`define SPIMP_GUARD_QUARTER 2'h1
`define SPIMP_GUARD_HALF 2'h2
`define SPIMP_GUARD_ALL 2'h3

// Address and counters
`define SPIMP_ADDR_W 15
`define SPIMP_MEM_DEPTH 32768
`define SPIMP_ADDR_STEP 15'h0001
`define SPIMP_ADDR_ZERO 15'h0000
`define SPIMP_QUARTER_TOP 2'h3
`define SPIMP_CNT_STEP 3'h1
`define SPIMP_CNT_ZERO 3'h0
`define SPIMP_CNT_LAST 3'h7
`define SPIMP_PIN_RESET 4'hd

`endif

// ### design/spimp_pkg.sv
package spimp_pkg;

  typedef enum logic [3:0] {
    PH_OPC,
    PH_ADDR,
    PH_DUMMY,
    PH_WDATA,
    PH_RDATA,
    PH_SRRD,
    PH_SRWR,
    PH_IGNORE
  } spimp_phase_t;

  typedef struct packed {
    logic sckPrev;
    spimp_phase_t phase;
    logic [2:0] bitCnt;
    logic [2:0] outCnt;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic [14:0] addr;
    logic addrLow;
    logic isQuick;
    logic isWrite;
    logic wrStop;
    logic clrPending;
    logic latch;
    logic [1:0] guard;
    logic pinEn;
    logic so;
    logic soOeN;
  } spimp_state_t;

endpackage

// ### design/spimp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module spimp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### design/spimp_top.sv
`include "spimp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module spimp_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic wpN,
  output logic soOut,
  output logic soOeN
);

  spimp_pkg::spimp_state_t st_q;
  spimp_pkg::spimp_state_t st_d;

  logic [7:0] memArr [0:`SPIMP_MEM_DEPTH-1];

  logic [3:0] pinRaw;
  logic [3:0] pinSync;
  logic csS;
  logic sckS;
  logic siS;
  logic wpS;

  logic sckRise;
  logic sckFall;
  logic receiving;
  logic byteDone;
  logic [7:0] newByte;
  logic [7:0] statusByte;
  logic [7:0] outByte;
  logic protHit;
  logic statusLocked;
  logic memWe;
  logic [14:0] memAddr;
  logic [7:0] memData;

  assign pinRaw = {csN, sck, si, wpN};

  // Link pins come from the master's clock domain
  spimp_sync #(
    .W(4),
    .RST_VAL(`SPIMP_PIN_RESET)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(pinRaw),
    .q(pinSync)
  );

  assign csS = pinSync[3];
  assign sckS = pinSync[2];
  assign siS = pinSync[1];
  assign wpS = pinSync[0];

  // Edges found from the sampled clock; rise samples input, fall shifts output
  assign sckRise = sckS & ~st_q.sckPrev;
  assign sckFall = ~sckS & st_q.sckPrev;

  assign newByte = {st_q.shiftIn[6:0], siS};

  // Input is not shifted while the block is talking or ignoring
  assign receiving = (st_q.phase != spimp_pkg::PH_RDATA) &&
                     (st_q.phase != spimp_pkg::PH_SRRD) &&
                     (st_q.phase != spimp_pkg::PH_IGNORE);

  assign byteDone = ~csS && sckRise && receiving &&
                    (st_q.bitCnt == `SPIMP_CNT_LAST);

  always_comb begin
    statusByte = `SPIMP_SR_RESET;
    statusByte[`SPIMP_SR_LATCH_BIT] = st_q.latch;
    statusByte[`SPIMP_SR_GUARD_LO_BIT] = st_q.guard[0];
    statusByte[`SPIMP_SR_GUARD_HI_BIT] = st_q.guard[1];
    statusByte[`SPIMP_SR_PIN_EN_BIT] = st_q.pinEn;
  end

  always_comb begin
    case (st_q.guard)
      `SPIMP_GUARD_NONE: protHit = 1'b0;
      `SPIMP_GUARD_QUARTER: protHit = (st_q.addr[14:13] == `SPIMP_QUARTER_TOP);
      `SPIMP_GUARD_HALF: protHit = st_q.addr[14];
      `SPIMP_GUARD_ALL: protHit = 1'b1;
      default: protHit = 1'b1;
    endcase
  end

  // The pin only guards the status register, never the array
  assign statusLocked = st_q.pinEn & ~wpS;

  always_comb begin
    st_d = st_q;
    memWe = 1'b0;
    memAddr = st_q.addr;
    memData = newByte;
    outByte = st_q.shiftOut;
    st_d.sckPrev = sckS;

    if (csS) begin
      // Deselected: pending latch clear lands here, on the select rise
      if (st_q.clrPending) begin
        st_d.latch = 1'b0;
      end
      st_d.clrPending = 1'b0;
      st_d.phase = spimp_pkg::PH_OPC;
      st_d.bitCnt = `SPIMP_CNT_ZERO;
      st_d.outCnt = `SPIMP_CNT_ZERO;
      st_d.addrLow = 1'b0;
      st_d.isQuick = 1'b0;
      st_d.isWrite = 1'b0;
      st_d.wrStop = 1'b0;
      st_d.soOeN = 1'b1;
    end else begin
      if (sckRise && receiving) begin
        st_d.shiftIn = newByte;
        st_d.bitCnt = st_q.bitCnt + `SPIMP_CNT_STEP;
      end

      if (byteDone) begin
        case (st_q.phase)
          spimp_pkg::PH_OPC: begin
            case (newByte)
              `SPIMP_OP_SET_WRITE_LATCH: begin
                st_d.latch = 1'b1;
                st_d.phase = spimp_pkg::PH_IGNORE;
              end
              `SPIMP_OP_CLEAR_WRITE_LATCH: begin
                st_d.clrPending = 1'b1;
                st_d.phase = spimp_pkg::PH_IGNORE;
              end
              `SPIMP_OP_STATUS_READ: begin
                st_d.phase = spimp_pkg::PH_SRRD;
              end
              `SPIMP_OP_STATUS_WRITE: begin
                st_d.clrPending = 1'b1;
                st_d.phase = spimp_pkg::PH_SRWR;
              end
              `SPIMP_OP_READ: begin
                st_d.phase = spimp_pkg::PH_ADDR;
              end
              `SPIMP_OP_QUICK_READ: begin
                st_d.isQuick = 1'b1;
                st_d.phase = spimp_pkg::PH_ADDR;
              end
              `SPIMP_OP_WRITE: begin
                st_d.isWrite = 1'b1;
                st_d.clrPending = 1'b1;
                st_d.phase = spimp_pkg::PH_ADDR;
              end
              default: begin
                st_d.phase = spimp_pkg::PH_IGNORE;
              end
            endcase
          end

          spimp_pkg::PH_ADDR: begin
            if (!st_q.addrLow) begin
              st_d.addr[14:8] = newByte[6:0];
              st_d.addrLow = 1'b1;
            end else begin
              st_d.addr[7:0] = newByte;
              if (st_q.isWrite) begin
                st_d.phase = spimp_pkg::PH_WDATA;
              end else if (st_q.isQuick) begin
                st_d.phase = spimp_pkg::PH_DUMMY;
              end else begin
                st_d.phase = spimp_pkg::PH_RDATA;
              end
            end
          end

          spimp_pkg::PH_DUMMY: begin
            st_d.phase = spimp_pkg::PH_RDATA;
          end

          spimp_pkg::PH_WDATA: begin
            // Latch low or a guarded address drops the rest of the burst
            if (!st_q.wrStop) begin
              if (!st_q.latch || protHit) begin
                st_d.wrStop = 1'b1;
              end else begin
                memWe = 1'b1;
                st_d.addr = st_q.addr + `SPIMP_ADDR_STEP;
              end
            end
          end

          spimp_pkg::PH_SRWR: begin
            if (st_q.latch && !statusLocked) begin
              st_d.pinEn = newByte[`SPIMP_SR_PIN_EN_BIT];
              st_d.guard[0] = newByte[`SPIMP_SR_GUARD_LO_BIT];
              st_d.guard[1] = newByte[`SPIMP_SR_GUARD_HI_BIT];
            end
            st_d.phase = spimp_pkg::PH_IGNORE;
          end

          default: begin
            st_d.phase = spimp_pkg::PH_IGNORE;
          end
        endcase
      end

      if (sckFall) begin
        case (st_q.phase)
          spimp_pkg::PH_RDATA: begin
            // Async array read so the first bit is ready on the first fall
            if (st_q.outCnt == `SPIMP_CNT_ZERO) begin
              outByte = memArr[st_q.addr];
            end
            st_d.so = outByte[7];
            st_d.soOeN = 1'b0;
            st_d.shiftOut = {outByte[6:0], 1'b0};
            st_d.outCnt = st_q.outCnt + `SPIMP_CNT_STEP;
            if (st_q.outCnt == `SPIMP_CNT_LAST) begin
              st_d.addr = st_q.addr + `SPIMP_ADDR_STEP;
            end
          end
          spimp_pkg::PH_SRRD: begin
            if (st_q.outCnt == `SPIMP_CNT_ZERO) begin
              outByte = statusByte;
            end
            st_d.so = outByte[7];
            st_d.soOeN = 1'b0;
            st_d.shiftOut = {outByte[6:0], 1'b0};
            st_d.outCnt = st_q.outCnt + `SPIMP_CNT_STEP;
            if (st_q.outCnt == `SPIMP_CNT_LAST) begin
              st_d.phase = spimp_pkg::PH_IGNORE;
            end
          end
          default: begin
            st_d.soOeN = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.sckPrev <= 1'b0;
      st_q.phase <= spimp_pkg::PH_OPC;
      st_q.latch <= 1'b0;
      st_q.so <= 1'b0;
      st_q.soOeN <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Array is not cleared by reset; it models retained contents
  always_ff @(posedge clk) begin
    if (memWe) begin
      memArr[memAddr] <= memData;
    end
  end

  assign soOut = st_q.so;
  assign soOeN = st_q.soOeN;

endmodule

`default_nettype wire

// ### design/spimp_top_fix_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### test/spimp_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module spimp_top_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic wpN,
  input wire logic soOut,
  input wire logic soOeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rst_idle;
    $fell(sys_rst) |-> soOeN && !soOut ##1 soOeN;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("Output not idle after reset");
  property p_cs_rise;
    $rose(csN) |-> ##[0:8] soOeN;
  endproperty
  a_cs_rise: assert property (p_cs_rise) else $error("Output not floated by select rise");
  property p_cs_idle;
    csN [*8] |-> soOeN;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("Output driven while deselected");
  property p_oe_sel;
    $fell(soOeN) |-> !csN;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("Drive began without select");
  // Full high phase is longer than the output path, so nothing may move
  property p_hi_stable;
    (sck && !csN) [*6] |-> $stable(soOut) && $stable(soOeN);
  endproperty
  a_hi_stable: assert property (p_hi_stable) else $error("Output moved in high phase");
  property p_oe_fall;
    $fell(soOeN) |-> !sck && $past(!sck, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("Drive not after falling edge");
  property p_out_low;
    $changed(soOut) && !soOeN |-> !sck;
  endproperty
  a_out_low: assert property (p_out_low) else $error("Data changed in high phase");
  property p_oe_rise;
    $rose(soOeN) |-> csN || !sck;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("Float at wrong moment");
endmodule

`default_nettype wire

// ### test/spimp_master.sv
`timescale 1ns/1ps
`default_nettype none

module spimp_master (
  input wire logic soOut,
  input wire logic soOeN,
  output logic csN,
  output logic sck,
  output logic si
);
  logic drv;
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    drv = 1'b0;
  end
  task automatic sel();
    csN = 1'b0;
    drv = 1'b0;
    #125;
  endtask
  // Mode 0 only; sck rests low between frames
  task automatic xb(input logic [7:0] o, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      si = o[i];
      #62.5 sck = 1'b1;
      r[i] = soOut;
      if (soOeN === 1'b0) drv = 1'b1;
      #62.5 sck = 1'b0;
    end
  endtask
  // Released si flips so stale data never looks valid
  task automatic desel();
    #62.5 csN = 1'b1;
    si = ~si;
    #125;
  endtask
endmodule

`default_nettype wire

// ### test/spimp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spimp_top_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wpN = 1'b1;
  logic csN, sck, si, soOut, soOeN;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] r;
  logic [7:0] mem [3];
  logic [15:0] pa [3] = '{16'h3fff, 16'h4000, 16'h6000};
  logic [15:0] lim [4] = '{16'h8000, 16'h6000, 16'h4000, 16'h0000};
  always #5 clk = ~clk;
  spimp_top DUT (.clk(clk), .sys_rst(sys_rst), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
    .soOut(soOut), .soOeN(soOeN));
  spimp_master m (.soOut(soOut), .soOeN(soOeN), .csN(csN), .sck(sck), .si(si));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic op(input logic [7:0] c, input logic [7:0] d, input bit n);
    m.sel();
    m.xb(c, r);
    if (n) m.xb(d, r);
    m.desel();
  endtask
  task automatic sr(input logic [7:0] e);
    op(8'h05, 8'hff, 1'b1);
    chk("status", e, r);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
    m.sel();
    m.xb(8'h02, r);
    m.xb(a[15:8], r);
    m.xb(a[7:0], r);
    foreach (d[i]) m.xb(d[i], r);
    m.desel();
  endtask
  task automatic rd(input logic [15:0] a, input bit q, input logic [7:0] e[$]);
    m.sel();
    m.xb(q ? 8'h0b : 8'h03, r);
    m.xb(a[15:8], r);
    m.xb(a[7:0], r);
    if (q) m.xb(8'h3c, r);
    foreach (e[i]) begin
      m.xb(~r, r);
      chk("rdata", e[i], r);
    end
    m.desel();
  endtask
  task automatic print_verdict();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    sr(8'h00);
    op(8'h06, 8'h00, 1'b0);
    sr(8'h02);
    op(8'h04, 8'h00, 1'b0);
    sr(8'h00);
    op(8'h06, 8'h00, 1'b0);
    wr(16'hfffe, '{8'hc0, 8'hc1, 8'hc2});
    rd(16'h7ffe, 1'b0, '{8'hc0, 8'hc1, 8'hc2});
    rd(16'hfffe, 1'b1, '{8'hc0, 8'hc1, 8'hc2});
    sr(8'h00);
    wr(16'h0000, '{8'h99});
    rd(16'h0000, 1'b0, '{8'hc2});
    for (int g = 0; g < 4; g++) begin
      op(8'h06, 8'h00, 1'b0);
      op(8'h01, {4'h0, g[1:0], 2'h0}, 1'b1);
      sr({4'h0, g[1:0], 2'h0});
      foreach (pa[k]) begin
        op(8'h06, 8'h00, 1'b0);
        wr(pa[k], '{{g[3:0], k[3:0]}});
        if (pa[k] < lim[g]) mem[k] = {g[3:0], k[3:0]};
        rd(pa[k], 1'b0, '{mem[k]});
      end
    end
    op(8'h06, 8'h00, 1'b0);
    op(8'h01, 8'hf7, 1'b1);
    sr(8'h84);
    @(posedge clk);
    wpN <= 1'b0;
    op(8'h06, 8'h00, 1'b0);
    op(8'h01, 8'h00, 1'b1);
    sr(8'h84);
    op(8'h06, 8'h00, 1'b0);
    wr(16'h5fff, '{8'he1, 8'he2, 8'he3});
    rd(16'h5fff, 1'b0, '{8'he1, mem[2]});
    m.sel();
    m.xb(8'h9f, r);
    m.xb(8'h05, r);
    m.desel();
    chk("drive", 8'h00, {7'h0, m.drv});
    print_verdict();
  end
  initial begin
    #500000;
    err_count++;
    print_verdict();
  end
endmodule

bind spimp_top spimp_top_props u_props (.clk(clk), .sys_rst(sys_rst), .csN(csN), .sck(sck),
  .si(si), .wpN(wpN), .soOut(soOut), .soOeN(soOeN));

`default_nettype wire
